// ===== rtl/timer0_consts.svh
// Constants for the 8-bit timer with flags and prescaler
// How it works
// - Software reads and writes the count at any time; a write replaces it.
// - A count write blocks the compare match on the next timer tick.
// - Both compare values are compared with the count; equality flags and drives outputs.
// - Interrupt asserts only when its enable, global enable and flag are one.
// - Compare A flag (bit 4) sets on match; clears by vector ack or write-one.
// - Compare B flag (bit 3) sets on match; clears by vector ack or write-one.
// - Overflow flag (bit 1) sets on overflow per waveform mode; clears likewise.
// - Reserved bits of mask and flag registers read as zero.
// - Select 1 counts every clock; selects 2 to 5 use taps 8, 64, 256, 1024.
// - The prescaler runs freely, independent of clock select.
// - The pin is sampled every clock; select 7 counts rising, 6 falling edges.
// - Synchroniser is a latch stage then rising-edge registers.
// - Pin edge reaches the count within 1.5 to 2.5 clocks.
// - External edges bypass the prescaler.
// - While sync hold is set, prescaler clear keeps its value; clearing hold clears it.
// - Writing one to prescaler clear resets it; self-clears unless hold is set.
// - Select zero stops the counter.
// - Forced compare strobes set no flag and raise no interrupt.
`ifndef TIMER0_CONSTS_SVH
`define TIMER0_CONSTS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_COUNT      12'h000
`define ADDR_CMP_A      12'h004
`define ADDR_CMP_B      12'h008
`define ADDR_IRQ_MASK   12'h00c
`define ADDR_IRQ_FLAGS  12'h010
`define ADDR_GEN_CTRL   12'h014
`define ADDR_TMR_CTRL   12'h018
// ****************************************
// Field positions
// ****************************************
`define BIT_CMP_A       4
`define BIT_CMP_B       3
`define BIT_OVF         1
`define BIT_EN_B        3
`define BIT_EN_A        2
`define BIT_EN_OVF      1
`define BIT_SYNC_HOLD   7
`define BIT_PSC_CLEAR   0
`define MASK_IRQ_MASK   8'h0e
`define MASK_IRQ_FLAGS  8'h1a
`define BYTE_ZERO       8'h00
`define BYTE_MAX        8'hff
// Timer control: bits 2:0 clock select, bits 5:3 waveform mode
`define TC_CS_LSB       0
`define TC_WG_LSB       3
// ****************************************
// Prescaler taps (counter bit whose wrap gives the tick)
// ****************************************
`define PSC_W           10
`define PSC_MASK_8      10'h007
`define PSC_MASK_64     10'h03f
`define PSC_MASK_256    10'h0ff
`define PSC_MASK_1024   10'h3ff
`endif

// ===== rtl/timer0_flags_prescaler.sv
// 8-bit timer with compare flags, prescaler and external count input
`timescale 1ns/10ps
`default_nettype none
`include "timer0_consts.svh"
module timer0_flags_prescaler #(
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ext_count_in,
    input  wire logic              global_irq_en,
    input  wire logic              ack_cmp_a,
    input  wire logic              ack_cmp_b,
    input  wire logic              ack_ovf,
    input  wire logic              force_cmp_a,
    input  wire logic              force_cmp_b,
    output logic                   irq_cmp_a,
    output logic                   irq_cmp_b,
    output logic                   irq_ovf,
    output logic                   wave_out_a,
    output logic                   wave_out_b
);
    initial begin
        if (ADDR_W < 5) $error("ADDR_W too small");
    end

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic       wr_en      = psel && penable && pwrite && pstrb[0];
    wire logic       sel_count  = paddr == ADDR_W'(`ADDR_COUNT);
    wire logic       sel_cmp_a  = paddr == ADDR_W'(`ADDR_CMP_A);
    wire logic       sel_cmp_b  = paddr == ADDR_W'(`ADDR_CMP_B);
    wire logic       sel_mask   = paddr == ADDR_W'(`ADDR_IRQ_MASK);
    wire logic       sel_flags  = paddr == ADDR_W'(`ADDR_IRQ_FLAGS);
    wire logic       sel_gen    = paddr == ADDR_W'(`ADDR_GEN_CTRL);
    wire logic       sel_tc     = paddr == ADDR_W'(`ADDR_TMR_CTRL);
    wire logic       mapped     = sel_count | sel_cmp_a | sel_cmp_b | sel_mask
                                | sel_flags | sel_gen | sel_tc;
    wire logic [7:0] wbyte      = pwdata[7:0];

    logic [7:0] count_value_q;
    logic [7:0] compare_a_value_q;
    logic [7:0] compare_b_value_q;
    logic [7:0] timer_irq_mask_q;
    logic [7:0] timer_irq_flags_q;
    logic       sync_hold_mode_q;
    logic       prescaler_clear_q;
    logic [5:0] timer_ctrl_q;
    logic [`PSC_W-1:0] psc_q;
    logic       pin_latch;
    logic       pin_s1_q;
    logic       pin_s2_q;
    logic       block_q;
    logic       wave_a_q;
    logic       wave_b_q;
    logic [31:0] prdata_q;

    wire timer0_pkg::clk_sel_t clock_source_sel =
        timer0_pkg::clk_sel_t'(timer_ctrl_q[`TC_CS_LSB +: 3]);
    wire logic [2:0] waveform_mode_sel = timer_ctrl_q[`TC_WG_LSB +: 3];

    // ****************************************
    // Prescaler and tick selection
    // ****************************************
    // Tap reached when all low bits of the free counter are ones
    function automatic logic tap_hit(input logic [`PSC_W-1:0] cnt,
                                     input logic [`PSC_W-1:0] msk);
        tap_hit = (cnt & msk) == msk;
    endfunction : tap_hit

    wire logic psc_reset  = prescaler_clear_q;
    wire logic ext_rise   = pin_s1_q & ~pin_s2_q;
    wire logic ext_fall   = ~pin_s1_q & pin_s2_q;
    logic      tick;
    always_comb begin
        // Clock source mux
        case (clock_source_sel)
            timer0_pkg::CS_STOP:     tick = 1'b0;
            timer0_pkg::CS_DIV1:     tick = 1'b1;
            timer0_pkg::CS_DIV8:     tick = !psc_reset && tap_hit(psc_q, `PSC_MASK_8);
            timer0_pkg::CS_DIV64:    tick = !psc_reset && tap_hit(psc_q, `PSC_MASK_64);
            timer0_pkg::CS_DIV256:   tick = !psc_reset && tap_hit(psc_q, `PSC_MASK_256);
            timer0_pkg::CS_DIV1024:  tick = !psc_reset && tap_hit(psc_q, `PSC_MASK_1024);
            timer0_pkg::CS_EXT_FALL: tick = ext_fall;
            timer0_pkg::CS_EXT_RISE: tick = ext_rise;
            default:                 tick = 1'b0;
        endcase
    end

    // Free-running prescaler, held only by its own clear bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) psc_q <= '0;
        else if (psc_reset) psc_q <= '0;
        else psc_q <= psc_q + 1'b1;
    end

    // ****************************************
    // External pin synchroniser
    // ****************************************
    // Latch open while clock is high, then two rising-edge stages
    always_latch begin
        if (mclk) pin_latch = ext_count_in;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_latch;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ****************************************
    // Counter, compare and overflow
    // ****************************************
    wire logic count_wr = wr_en && sel_count;
    wire logic match_a  = count_value_q == compare_a_value_q;
    wire logic match_b  = count_value_q == compare_b_value_q;
    wire logic ctc_mode = waveform_mode_sel[1:0] == 2'b10;
    wire logic [7:0] top = ctc_mode ? compare_a_value_q : `BYTE_MAX;
    wire logic at_top   = count_value_q == top;
    // Compare events: on ticks only, unless a count write blocked this tick
    wire logic cmp_a_ev = tick && match_a && !block_q;
    wire logic cmp_b_ev = tick && match_b && !block_q;
    wire logic ovf_ev   = tick && at_top && !count_wr;
    wire logic [7:0] count_next = at_top ? `BYTE_ZERO : count_value_q + 8'h01;

    // Count register: bus write wins over a tick
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) count_value_q <= `BYTE_ZERO;
        else if (count_wr) count_value_q <= wbyte;
        else if (tick) count_value_q <= count_next;
    end

    // Block flag lives until the next timer tick after a count write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) block_q <= 1'b0;
        else if (count_wr) block_q <= 1'b1;
        else if (tick) block_q <= 1'b0;
    end

    // Compare values
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            compare_a_value_q <= `BYTE_ZERO;
            compare_b_value_q <= `BYTE_ZERO;
        end else begin
            if (wr_en && sel_cmp_a) compare_a_value_q <= wbyte;
            if (wr_en && sel_cmp_b) compare_b_value_q <= wbyte;
        end
    end

    // Waveform outputs toggle on match or forced strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else begin
            if (cmp_a_ev || force_cmp_a) wave_a_q <= !wave_a_q;
            if (cmp_b_ev || force_cmp_b) wave_b_q <= !wave_b_q;
        end
    end
    assign wave_out_a = wave_a_q;
    assign wave_out_b = wave_b_q;

    // ****************************************
    // Mask, flags and controls
    // ****************************************
    wire logic flag_wr = wr_en && sel_flags;
    wire logic [7:0] flag_set = {3'b000, cmp_a_ev, cmp_b_ev, 1'b0, ovf_ev, 1'b0};
    wire logic [7:0] flag_clr = ({8{flag_wr}} & wbyte)
                              | {3'b000, ack_cmp_a, ack_cmp_b, 1'b0, ack_ovf, 1'b0};

    // Set wins over clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) timer_irq_flags_q <= `BYTE_ZERO;
        else timer_irq_flags_q <= ((timer_irq_flags_q & ~flag_clr) | flag_set)
                                  & `MASK_IRQ_FLAGS;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) timer_irq_mask_q <= `BYTE_ZERO;
        else if (wr_en && sel_mask) timer_irq_mask_q <= wbyte & `MASK_IRQ_MASK;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) timer_ctrl_q <= '0;
        else if (wr_en && sel_tc) timer_ctrl_q <= wbyte[5:0];
    end

    // Hold keeps the clear bit; otherwise it lasts one cycle
    wire logic gen_wr = wr_en && sel_gen;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_hold_mode_q  <= 1'b0;
            prescaler_clear_q <= 1'b0;
        end else if (gen_wr) begin
            sync_hold_mode_q  <= wbyte[`BIT_SYNC_HOLD];
            prescaler_clear_q <= wbyte[`BIT_PSC_CLEAR];
        end else if (!sync_hold_mode_q) begin
            prescaler_clear_q <= 1'b0;
        end
    end

    // Interrupt requests
    assign irq_cmp_a = global_irq_en && timer_irq_mask_q[`BIT_EN_A]
                     && timer_irq_flags_q[`BIT_CMP_A];
    assign irq_cmp_b = global_irq_en && timer_irq_mask_q[`BIT_EN_B]
                     && timer_irq_flags_q[`BIT_CMP_B];
    assign irq_ovf   = global_irq_en && timer_irq_mask_q[`BIT_EN_OVF]
                     && timer_irq_flags_q[`BIT_OVF];

    // ****************************************
    // Read path
    // ****************************************
    wire logic [7:0] gen_rd = {sync_hold_mode_q, 6'b000000, prescaler_clear_q};
    wire logic [7:0] rd_byte = ({8{sel_count}} & count_value_q)
                             | ({8{sel_cmp_a}} & compare_a_value_q)
                             | ({8{sel_cmp_b}} & compare_b_value_q)
                             | ({8{sel_mask}}  & timer_irq_mask_q)
                             | ({8{sel_flags}} & timer_irq_flags_q)
                             | ({8{sel_gen}}   & gen_rd)
                             | ({8{sel_tc}}    & {2'b00, timer_ctrl_q});

    // Read data registered in the setup cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) prdata_q <= '0;
        else if (psel && !penable) prdata_q <= {24'h000000, rd_byte};
    end
    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule : timer0_flags_prescaler
`default_nettype wire

// ===== rtl/timer0_pkg.sv
// Types for the 8-bit timer
package timer0_pkg;
    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
    } clk_sel_t;
endpackage : timer0_pkg

// ===== test/testbench.sv
// Register-level test of the 8-bit timer
`timescale 1ns/10ps
`default_nettype none
`include "timer0_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        ext_count_in = 1'h0, global_irq_en = 1'h0, ack_cmp_a = 1'h0, wv, se;
    logic        ack_cmp_b = 1'h0, ack_ovf = 1'h0, force_cmp_a = 1'h0, force_cmp_b = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [7:0]  rd, v;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, irq_cmp_a, irq_cmp_b, irq_ovf, wave_out_a, wave_out_b;
    wire logic [2:0] irqs = {irq_ovf, irq_cmp_b, irq_cmp_a};
    int          err_count = 0, num_checks = 0;
    int          dv[5] = '{1, 8, 64, 256, 1024};
    timer0_flags_prescaler u_timer0_flags_prescaler (.mclk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_count_in, .global_irq_en,
        .ack_cmp_a, .ack_cmp_b, .ack_ovf, .force_cmp_a, .force_cmp_b, .irq_cmp_a,
        .irq_cmp_b, .irq_ovf, .wave_out_a, .wave_out_b);
    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;
    // ****************************************
    // Bus and pin tasks
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) err_count++;
        rd = prdata[7:0];
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        `CHK(rd, e)
    endtask : chk_rd
    task automatic wait_irq(input int k);
        for (int n = 0; n < 400 && irqs[k] !== 1'h1; n++)
            @(posedge mclk);
    endtask : wait_irq
    // Pin pulses, each half period four clocks
    task automatic pins(input int k);
        repeat (k) begin
            ext_count_in <= 1'h1;
            repeat (4) @(posedge mclk);
            ext_count_in <= 1'h0;
            repeat (4) @(posedge mclk);
        end
    endtask : pins
    task stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // Watchdog against a hung bus or counter
    initial begin
        repeat (60000) @(posedge mclk);
        err_count++;
        stop_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        for (int a = 0; a < 7; a++)
            chk_rd(12'(4 * a), 8'h00);
        apb(1'h0, 12'h01c, 8'h00);
        `CHK({se, rd}, 9'h100)
        global_irq_en <= 1'h1;
        apb(1'h1, `ADDR_CMP_A, 8'h20);
        apb(1'h1, `ADDR_CMP_B, 8'h30);
        apb(1'h1, `ADDR_IRQ_MASK, 8'hff);
        chk_rd(`ADDR_IRQ_MASK, 8'h0e);
        wv = wave_out_a;
        apb(1'h1, `ADDR_TMR_CTRL, 8'h01);
        wait_irq(0);
        `CHK(irqs, 3'h1)
        @(posedge mclk);
        `CHK(wave_out_a, ~wv)
        wait_irq(1);
        chk_rd(`ADDR_IRQ_FLAGS, 8'h18);
        global_irq_en <= 1'h0;
        repeat (2) @(posedge mclk);
        `CHK(irqs, 3'h0)
        global_irq_en <= 1'h1;
        ack_cmp_a <= 1'h1;
        @(posedge mclk);
        ack_cmp_a <= 1'h0;
        apb(1'h1, `ADDR_IRQ_FLAGS, 8'h08);
        @(posedge mclk);
        `CHK(irqs, 3'h0)
        apb(1'h1, `ADDR_COUNT, 8'h20);
        chk_rd(`ADDR_IRQ_FLAGS, 8'h00);
        apb(1'h1, `ADDR_COUNT, 8'hf0);
        wait_irq(2);
        `CHK(irqs, 3'h4)
        apb(1'h1, `ADDR_IRQ_FLAGS, 8'h02);
        @(posedge mclk);
        `CHK(irqs, 3'h0)
        apb(1'h1, `ADDR_TMR_CTRL, 8'h00);
        apb(1'h0, `ADDR_COUNT, 8'h00);
        v = rd;
        repeat (20) @(posedge mclk);
        chk_rd(`ADDR_COUNT, v);
        wv = wave_out_b;
        force_cmp_b <= 1'h1;
        @(posedge mclk);
        force_cmp_b <= 1'h0;
        repeat (2) @(posedge mclk);
        `CHK(wave_out_b, ~wv)
        `CHK(irqs, 3'h0)
        // Clock selections 1 to 5, sixteen ticks each
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, `ADDR_COUNT, 8'h00);
            apb(1'h1, `ADDR_TMR_CTRL, 8'(i + 1));
            repeat (16 * dv[i]) @(posedge mclk);
            apb(1'h1, `ADDR_TMR_CTRL, 8'h00);
            apb(1'h0, `ADDR_COUNT, 8'h00);
            `CHK(rd inside {[8'h0f:8'h14]}, 1'h1)
        end
        apb(1'h1, `ADDR_GEN_CTRL, 8'h01);
        chk_rd(`ADDR_GEN_CTRL, 8'h00);
        apb(1'h1, `ADDR_GEN_CTRL, 8'h81);
        apb(1'h1, `ADDR_COUNT, 8'h00);
        apb(1'h1, `ADDR_TMR_CTRL, 8'h02);
        repeat (100) @(posedge mclk);
        chk_rd(`ADDR_COUNT, 8'h00);
        chk_rd(`ADDR_GEN_CTRL, 8'h81);
        apb(1'h1, `ADDR_GEN_CTRL, 8'h00);
        chk_rd(`ADDR_GEN_CTRL, 8'h00);
        repeat (100) @(posedge mclk);
        apb(1'h0, `ADDR_COUNT, 8'h00);
        `CHK(rd != 8'h00, 1'h1)
        // Pin counting, enabled only while the pin rests low
        apb(1'h1, `ADDR_TMR_CTRL, 8'h00);
        apb(1'h1, `ADDR_COUNT, 8'h00);
        apb(1'h1, `ADDR_TMR_CTRL, 8'h07);
        pins(5);
        chk_rd(`ADDR_COUNT, 8'h05);
        apb(1'h1, `ADDR_TMR_CTRL, 8'h00);
        apb(1'h1, `ADDR_COUNT, 8'h00);
        apb(1'h1, `ADDR_TMR_CTRL, 8'h06);
        pins(5);
        chk_rd(`ADDR_COUNT, 8'h05);
        stop_test();
    end
endmodule : testbench
`default_nettype wire

// ===== test/timer0_assertions.sv
// Port-level checks for the 8-bit timer
`timescale 1ns/10ps
`default_nettype none
module timer0_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        global_irq_en,
    input wire logic        ack_cmp_a,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        irq_cmp_a,
    input wire logic        irq_cmp_b,
    input wire logic        irq_ovf
);
    // ****************************************
    // Interrupt gating and bus answers
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    irq_a_gate_a: assert property (irq_cmp_a |-> global_irq_en)
        else $error("compare a irq without global enable");
    irq_b_gate_a: assert property (irq_cmp_b |-> global_irq_en)
        else $error("compare b irq without global enable");
    ovf_gate_a: assert property (irq_ovf |-> global_irq_en)
        else $error("overflow irq without global enable");
    a_sticky_a: assert property (irq_cmp_a && global_irq_en && !ack_cmp_a && !(psel && pwrite)
        |=> irq_cmp_a || !global_irq_en) else $error("compare a irq dropped without a clear");
    prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside a setup cycle");
    upper_zero_a: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");
    bad_read_a: assert property (psel && penable && pslverr |-> prdata == 32'h00000000)
        else $error("unmapped read returned data");
endmodule : timer0_checker
bind timer0_flags_prescaler timer0_checker u_timer0_checker (.mclk, .rst_n, .psel, .penable,
    .pwrite, .global_irq_en, .ack_cmp_a, .prdata, .pslverr, .irq_cmp_a, .irq_cmp_b, .irq_ovf);
`default_nettype wire
